// ### src/ccw_chip_control.sv
`timescale 1ns/1ps
`default_nettype none

module ccw_chip_control #(
	parameter logic [20:0] BLINK_PERIOD_CYC = 21'(ccw_pkg::CCW_BLINK_PERIOD_CYC),
	parameter logic [20:0] BLINK_ON_CYC = 21'(ccw_pkg::CCW_BLINK_ON_CYC)
) (
	input wire logic CLOCK,
	input wire logic RESETN,
	input wire logic CE,
	// Host I/O register window
	input wire logic [6:0] IO_ADDR,
	input wire logic IO_RD,
	input wire logic IO_WR,
	input wire logic [3:0] IO_BE,
	input wire logic [31:0] IO_WDATA,
	output logic [31:0] IO_RDATA,
	output logic IO_ACK,
	// EEPROM loader, same clock
	input wire logic EE_BYTE_VALID,
	input wire logic [7:0] EE_BYTE,
	input wire logic HOST_CONFIG_DONE,
	// Strap pins
	input wire logic [5:0] EXPANSION_DATA_PINS,
	// Network status, same clock
	input wire logic LINK_VALID,
	input wire logic LINK_SPEED_100,
	input wire logic FULL_DUPLEX,
	input wire logic RX_BUSY,
	input wire logic TX_BUSY,
	input wire logic COLLISION,
	// Host side boot ROM requests
	input wire logic ROM_ACC_RD,
	input wire logic ROM_ACC_WR,
	input wire logic [15:0] ROM_ACC_ADDR,
	input wire logic [31:0] ROM_ACC_WDATA,
	input wire logic [31:0] ROM_DEV_RDATA,
	output logic [31:0] ROM_ACC_RDATA,
	output logic ROM_DEV_RD,
	output logic ROM_DEV_WR,
	output logic [15:0] ROM_DEV_ADDR,
	output logic [31:0] ROM_DEV_WDATA,
	// Control word fields seen by the rest of the chip
	output logic LOGIC_CLOCK_SOURCE_SELECT,
	output logic BOOT_ROM_SIZE_SELECT,
	output logic TX_OVERSIZE_ENABLE,
	output logic RX_OVERSIZE_ENABLE,
	output logic BOOT_ROM_BLOCK,
	output logic [1:0] PRESET_CONFIG_SELECT,
	output logic ALT_IDENTITY_SELECT,
	output logic SIM_ACCELERATE,
	// Preset decode outcome
	output logic HOST_ACCESS_OK,
	output logic [15:0] PRESET_IO_BASE,
	output logic PRESET_IO_ENABLE,
	output logic PRESET_MEM_ENABLE,
	output logic PRESET_MASTER_ENABLE,
	output logic PRESET_ROM_ENABLE,
	// Indicators, active low
	output logic POWER_INDICATOR_N,
	output logic LINK_ACTIVITY_INDICATOR_N,
	output logic DUPLEX_INDICATOR_N,
	output logic SPEED_INDICATOR_N
);

	////////////////////////////////////////////////////////////////////////
	// Helpers

	// Merge one byte lane under its enable
	function automatic logic [7:0] lane_merge(input logic [7:0] old_v, input logic [7:0] new_v,
		input logic en);
		lane_merge = en ? new_v : old_v;
	endfunction

	// Indicator level: blink beats steady on, else off
	function automatic logic indicator_level(input logic steady_on, input logic blinking,
		input logic blink_low);
		if (blinking) begin
			indicator_level = blink_low;
		end else begin
			indicator_level = !steady_on;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// State

	logic [7:0] low_byte_r;
	logic [1:0] preset_r;
	logic id_sel_r;
	logic sim_accel_r;
	logic ind_style_r;
	logic [5:0] strap_meta_r;
	logic [5:0] strap_sync_r;
	ccw_pkg::ccw_strap_e strap_st_r;
	ccw_pkg::ccw_strap_e strap_st_nxt;
	logic ee_loaded_r;
	logic [20:0] blink_cnt_r;
	logic blink_low_r;
	logic collision_hold_r;
	logic [20:0] period_lim;
	logic [20:0] on_lim;
	logic reg_hit;
	logic [31:0] word_view;
	logic preset1;
	logic rom_off;
	logic wrap;

	// Only 01 is a live preset; 1X stays reserved and acts as none
	assign preset1 = (preset_r == ccw_pkg::CCW_PRESET_MODE1);
	assign reg_hit = (IO_ADDR[6:2] == ccw_pkg::CCW_CHIP_CONTROL_OFFSET[6:2]);
	// ROM blocked by bit or preset
	assign rom_off = low_byte_r[ccw_pkg::CCW_ROM_BLOCK_BIT] || preset1;

	// Read view of the control word
	always_comb begin
		word_view = 32'h00000000;
		word_view[7:0] = low_byte_r;
		word_view[ccw_pkg::CCW_PRESET_HI_BIT:ccw_pkg::CCW_PRESET_LO_BIT] = preset_r;
		word_view[ccw_pkg::CCW_ID_SEL_BIT] = id_sel_r;
		word_view[12:11] = 2'h0;
		word_view[ccw_pkg::CCW_SIM_ACCEL_BIT] = sim_accel_r;
		word_view[ccw_pkg::CCW_IND_STYLE_BIT] = ind_style_r;
	end

	////////////////////////////////////////////////////////////////////////
	// Strap capture

	// Pins are asynchronous; only the second stage is read by logic
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			strap_meta_r <= 6'h00;
			strap_sync_r <= 6'h00;
		end else if (CE) begin
			strap_meta_r <= EXPANSION_DATA_PINS;
			strap_sync_r <= strap_meta_r;
		end
	end

	// Wait two edges so the synchroniser holds post-reset pin levels
	always_comb begin
		unique case (strap_st_r)
			ccw_pkg::CCW_ST_SYNC_A: strap_st_nxt = ccw_pkg::CCW_ST_SYNC_B;
			ccw_pkg::CCW_ST_SYNC_B: strap_st_nxt = ccw_pkg::CCW_ST_LOAD;
			ccw_pkg::CCW_ST_LOAD: strap_st_nxt = ccw_pkg::CCW_ST_RUN;
			ccw_pkg::CCW_ST_RUN: strap_st_nxt = ccw_pkg::CCW_ST_RUN;
			default: strap_st_nxt = ccw_pkg::CCW_ST_SYNC_A;
		endcase
	end

	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			strap_st_r <= ccw_pkg::CCW_ST_SYNC_A;
		end else if (CE) begin
			strap_st_r <= strap_st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register writes

	// Low byte: EEPROM image, then host writes the writable bits
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			low_byte_r <= ccw_pkg::CCW_LOW_BYTE_RESET;
			ee_loaded_r <= 1'b0;
		end else if (CE) begin
			if (EE_BYTE_VALID) begin
				low_byte_r <= EE_BYTE;
				ee_loaded_r <= 1'b1;
			end else if (IO_WR && reg_hit && IO_BE[0]) begin
				low_byte_r[ccw_pkg::CCW_TX_OVERSIZE_BIT] <= IO_WDATA[ccw_pkg::CCW_TX_OVERSIZE_BIT];
				low_byte_r[ccw_pkg::CCW_RX_OVERSIZE_BIT] <= IO_WDATA[ccw_pkg::CCW_RX_OVERSIZE_BIT];
				low_byte_r[ccw_pkg::CCW_ROM_BLOCK_BIT] <= IO_WDATA[ccw_pkg::CCW_ROM_BLOCK_BIT];
			end
		end
	end

	// Upper control fields: straps at start-up, host writes afterwards
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			preset_r <= ccw_pkg::CCW_PRESET_RESET;
			id_sel_r <= 1'b0;
			sim_accel_r <= 1'b0;
		end else if (CE) begin
			if (strap_st_r == ccw_pkg::CCW_ST_LOAD) begin
				preset_r <= {strap_sync_r[ccw_pkg::CCW_STRAP_PRESET_HI_PIN],
					strap_sync_r[ccw_pkg::CCW_STRAP_PRESET_LO_PIN]};
				id_sel_r <= strap_sync_r[ccw_pkg::CCW_STRAP_ID_PIN];
				sim_accel_r <= strap_sync_r[ccw_pkg::CCW_STRAP_SIM_PIN];
			end else if (IO_WR && reg_hit && IO_BE[1]) begin
				preset_r <= IO_WDATA[ccw_pkg::CCW_PRESET_HI_BIT:ccw_pkg::CCW_PRESET_LO_BIT];
				id_sel_r <= IO_WDATA[ccw_pkg::CCW_ID_SEL_BIT];
				sim_accel_r <= IO_WDATA[ccw_pkg::CCW_SIM_ACCEL_BIT];
			end
		end
	end

	// Indicator style has no strap
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			ind_style_r <= 1'b0;
		end else if (CE) begin
			if (IO_WR && reg_hit && IO_BE[1]) begin
				ind_style_r <= IO_WDATA[ccw_pkg::CCW_IND_STYLE_BIT];
			end
		end
	end

	// Register read port, answered one edge after the strobe
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			IO_RDATA <= 32'h00000000;
			IO_ACK <= 1'b0;
		end else if (CE) begin
			IO_ACK <= (IO_RD || IO_WR) && reg_hit;
			if (IO_RD && reg_hit) begin
				IO_RDATA[7:0] <= lane_merge(8'h00, word_view[7:0], IO_BE[0]);
				IO_RDATA[15:8] <= lane_merge(8'h00, word_view[15:8], IO_BE[1]);
				IO_RDATA[31:16] <= 16'h0000;
			end else begin
				IO_RDATA <= 32'h00000000;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Configuration outputs

	// Registered field copies; outputs lag the register bits by one edge
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			LOGIC_CLOCK_SOURCE_SELECT <= 1'b0;
			BOOT_ROM_SIZE_SELECT <= 1'b0;
			TX_OVERSIZE_ENABLE <= 1'b0;
			RX_OVERSIZE_ENABLE <= 1'b0;
			BOOT_ROM_BLOCK <= 1'b0;
			PRESET_CONFIG_SELECT <= ccw_pkg::CCW_PRESET_RESET;
			ALT_IDENTITY_SELECT <= 1'b0;
			SIM_ACCELERATE <= 1'b0;
		end else if (CE) begin
			LOGIC_CLOCK_SOURCE_SELECT <= low_byte_r[ccw_pkg::CCW_CLK_SRC_BIT];
			BOOT_ROM_SIZE_SELECT <= low_byte_r[ccw_pkg::CCW_ROM_SIZE_BIT];
			TX_OVERSIZE_ENABLE <= low_byte_r[ccw_pkg::CCW_TX_OVERSIZE_BIT];
			RX_OVERSIZE_ENABLE <= low_byte_r[ccw_pkg::CCW_RX_OVERSIZE_BIT];
			BOOT_ROM_BLOCK <= low_byte_r[ccw_pkg::CCW_ROM_BLOCK_BIT];
			PRESET_CONFIG_SELECT <= preset_r;
			ALT_IDENTITY_SELECT <= id_sel_r;
			SIM_ACCELERATE <= sim_accel_r;
		end
	end

	// Preset decode and host access gate
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			HOST_ACCESS_OK <= 1'b0;
			PRESET_IO_BASE <= 16'h0000;
			PRESET_IO_ENABLE <= 1'b0;
			PRESET_MEM_ENABLE <= 1'b0;
			PRESET_MASTER_ENABLE <= 1'b0;
			PRESET_ROM_ENABLE <= 1'b0;
		end else if (CE) begin
			// preset needs no config or EEPROM
			HOST_ACCESS_OK <= preset1 || (HOST_CONFIG_DONE && ee_loaded_r);
			PRESET_IO_BASE <= preset1 ? ccw_pkg::CCW_PRESET_IO_BASE : 16'h0000;
			PRESET_IO_ENABLE <= preset1;
			PRESET_MEM_ENABLE <= 1'b0;
			PRESET_MASTER_ENABLE <= preset1;
			PRESET_ROM_ENABLE <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Boot ROM access gate

	// Requests pass one edge later; blocked ones never reach the ROM
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			ROM_DEV_RD <= 1'b0;
			ROM_DEV_WR <= 1'b0;
			ROM_DEV_ADDR <= 16'h0000;
			ROM_DEV_WDATA <= 32'h00000000;
			ROM_ACC_RDATA <= 32'h00000000;
		end else if (CE) begin
			ROM_DEV_RD <= ROM_ACC_RD && !rom_off;
			ROM_DEV_WR <= ROM_ACC_WR && !rom_off;
			if (low_byte_r[ccw_pkg::CCW_ROM_SIZE_BIT]) begin
				ROM_DEV_ADDR <= ROM_ACC_ADDR;
			end else begin
				ROM_DEV_ADDR <= {1'b0, ROM_ACC_ADDR[ccw_pkg::CCW_ROM_AW_SMALL-1:0]};
			end
			ROM_DEV_WDATA <= ROM_ACC_WDATA;
			ROM_ACC_RDATA <= rom_off ? 32'h00000000 : ROM_DEV_RDATA;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Blink timing

	// Speedup divides the period; on/off ratio is kept
	assign period_lim = sim_accel_r ? (BLINK_PERIOD_CYC >> ccw_pkg::CCW_SIM_ACCEL_SHIFT)
		: BLINK_PERIOD_CYC;
	assign on_lim = sim_accel_r ? (BLINK_ON_CYC >> ccw_pkg::CCW_SIM_ACCEL_SHIFT) : BLINK_ON_CYC;
	assign wrap = (blink_cnt_r >= period_lim - 21'h000001);

	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			blink_cnt_r <= 21'h000000;
			blink_low_r <= 1'b1;
		end else if (CE) begin
			blink_cnt_r <= wrap ? 21'h000000 : blink_cnt_r + 21'h000001;
			// low for on phase, high rest
			blink_low_r <= wrap ? 1'b0 : !(blink_cnt_r + 21'h000001 < on_lim);
		end
	end

	// Collisions are short pulses; hold them until the next period wrap so they show
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			collision_hold_r <= 1'b0;
		end else if (CE) begin
			if (COLLISION) begin
				collision_hold_r <= 1'b1;
			end else if (wrap) begin
				collision_hold_r <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Indicator outputs

	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			POWER_INDICATOR_N <= 1'b1;
			LINK_ACTIVITY_INDICATOR_N <= 1'b1;
			DUPLEX_INDICATOR_N <= 1'b1;
			SPEED_INDICATOR_N <= 1'b1;
		end else if (CE) begin
			// power blinks on transmit in style 0
			POWER_INDICATOR_N <= indicator_level(1'b1, !ind_style_r && TX_BUSY, blink_low_r);
			LINK_ACTIVITY_INDICATOR_N <= indicator_level(LINK_VALID,
				ind_style_r ? (RX_BUSY || TX_BUSY) : RX_BUSY, blink_low_r);
			DUPLEX_INDICATOR_N <= indicator_level(FULL_DUPLEX,
				!FULL_DUPLEX && !ind_style_r && collision_hold_r, blink_low_r);
			SPEED_INDICATOR_N <= indicator_level(LINK_VALID && LINK_SPEED_100, 1'b0, blink_low_r);
		end
	end

endmodule

`default_nettype wire

// ### src/ccw_pkg.sv
// What this block does
// - Reset clears low byte; EEPROM load fills it
// - Bit 0 reports logic clock source
// - Bit 1 ROM size; decode follows
// - Bit 4 blocks ROM; reads zero
// - Bit 2 enables oversize transmit frames
// - Bit 3 enables oversize receive frames
// - Bit 5 reports 10 Mbps capability
// - Bit 6 reports 100 Mbps capability
// - Bit 7 reports media type
// - Bits 9:8 preset mode, strapped
// - Preset 1 fixes base and enables
// - Preset mode skips config and EEPROM
// - Bit 10 picks alternate identity, strapped
// - Bit 13 simulation speedup, strapped
// - Bit 14 selects indicator style
// - Blink 41.89ms period, 5.24ms on
// - Link indicator low, blinks on receive, and on transmit in style 1 only
// - Duplex indicator low full, style rules
package ccw_pkg;

	// Register placement in the I/O window
	localparam logic [6:0] CCW_CHIP_CONTROL_OFFSET = 7'h30;

	// Field positions of the chip control word
	localparam int CCW_CLK_SRC_BIT = 0;
	localparam int CCW_ROM_SIZE_BIT = 1;
	localparam int CCW_TX_OVERSIZE_BIT = 2;
	localparam int CCW_RX_OVERSIZE_BIT = 3;
	localparam int CCW_ROM_BLOCK_BIT = 4;
	localparam int CCW_CAP_10M_BIT = 5;
	localparam int CCW_CAP_100M_BIT = 6;
	localparam int CCW_MEDIA_BIT = 7;
	localparam int CCW_PRESET_LO_BIT = 8;
	localparam int CCW_PRESET_HI_BIT = 9;
	localparam int CCW_ID_SEL_BIT = 10;
	localparam int CCW_SIM_ACCEL_BIT = 13;
	localparam int CCW_IND_STYLE_BIT = 14;

	// Reset values
	localparam logic [7:0] CCW_LOW_BYTE_RESET = 8'h00;
	localparam logic [1:0] CCW_PRESET_RESET = 2'h0;
	localparam logic [1:0] CCW_PRESET_MODE1 = 2'h1;

	// Fixed decode for preset mode 1
	localparam logic [15:0] CCW_PRESET_IO_BASE = 16'h0200;

	// Strap pin positions on the expansion data pins
	localparam int CCW_STRAP_ID_PIN = 2;
	localparam int CCW_STRAP_PRESET_LO_PIN = 3;
	localparam int CCW_STRAP_PRESET_HI_PIN = 4;
	localparam int CCW_STRAP_SIM_PIN = 5;

	// Boot ROM address widths for 32kB and 64kB parts
	localparam int CCW_ROM_AW_SMALL = 15;
	localparam int CCW_ROM_AW_LARGE = 16;

	// Blink timing, times in units of 10 us
	localparam longint CCW_CLK_HZ = 64'd25000000;
	localparam longint CCW_TIME_UNITS_PER_S = 64'd100000;
	localparam longint CCW_BLINK_PERIOD_T10US = 64'd4189;
	localparam longint CCW_BLINK_ON_T10US = 64'd524;
	localparam longint CCW_BLINK_OFF_T10US = 64'd3665;
	localparam longint CCW_BLINK_PERIOD_CYC =
		CCW_BLINK_PERIOD_T10US * CCW_CLK_HZ / CCW_TIME_UNITS_PER_S;
	localparam longint CCW_BLINK_ON_CYC =
		CCW_BLINK_ON_T10US * CCW_CLK_HZ / CCW_TIME_UNITS_PER_S;
	localparam longint CCW_BLINK_OFF_CYC =
		CCW_BLINK_OFF_T10US * CCW_CLK_HZ / CCW_TIME_UNITS_PER_S;
	localparam int CCW_BLINK_CW = 21;
	localparam int CCW_SIM_ACCEL_SHIFT = 6;

	// Strap capture sequence after reset release
	typedef enum logic [3:0] {
		CCW_ST_SYNC_A = 4'h1,
		CCW_ST_SYNC_B = 4'h2,
		CCW_ST_LOAD = 4'h4,
		CCW_ST_RUN = 4'h8
	} ccw_strap_e;

endpackage

// ### testbench/ccw_chip_control_properties.sv
`timescale 1ns/1ps
`default_nettype none

module ccw_cc_props (
	input wire logic CLOCK,
	input wire logic RESETN,
	input wire logic CE,
	input wire logic [6:0] IO_ADDR,
	input wire logic IO_RD,
	input wire logic IO_WR,
	input wire logic [31:0] IO_RDATA,
	input wire logic IO_ACK,
	input wire logic FULL_DUPLEX,
	input wire logic LINK_VALID,
	input wire logic RX_BUSY,
	input wire logic TX_BUSY,
	input wire logic ROM_ACC_RD,
	input wire logic [31:0] ROM_ACC_RDATA,
	input wire logic ROM_DEV_RD,
	input wire logic BOOT_ROM_BLOCK,
	input wire logic [1:0] PRESET_CONFIG_SELECT,
	input wire logic HOST_ACCESS_OK,
	input wire logic [15:0] PRESET_IO_BASE,
	input wire logic PRESET_IO_ENABLE,
	input wire logic PRESET_MEM_ENABLE,
	input wire logic PRESET_MASTER_ENABLE,
	input wire logic PRESET_ROM_ENABLE,
	input wire logic LINK_ACTIVITY_INDICATOR_N,
	input wire logic DUPLEX_INDICATOR_N
);
	// Request taken this edge for the control word
	logic hit;
	assign hit = CE && (IO_RD || IO_WR) && (IO_ADDR[6:2] == 5'h0C);

	// One clock domain, so one default for all
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (!RESETN);

	a_ack_timing: assert property (CE |=> IO_ACK == $past(hit))
		else $error("ack does not follow a hit");
	a_reserved_zero: assert property (IO_ACK |-> IO_RDATA[31:15] == 17'h0 && IO_RDATA[12:11] == 2'h0)
		else $error("reserved bits read nonzero");
	a_rom_data_gate: assert property ((BOOT_ROM_BLOCK || PRESET_CONFIG_SELECT == 2'h1)
		|-> ROM_ACC_RDATA == 32'h0)
		else $error("blocked rom read data nonzero");
	a_rom_strobe_gate: assert property ((CE && ROM_ACC_RD) |=> ROM_DEV_RD ==
		!(BOOT_ROM_BLOCK || PRESET_CONFIG_SELECT == 2'h1))
		else $error("rom strobe disagrees with block");
	a_preset_decode: assert property ((PRESET_CONFIG_SELECT == 2'h1) |-> PRESET_IO_BASE ==
		16'h0200 && PRESET_IO_ENABLE && PRESET_MASTER_ENABLE && !PRESET_MEM_ENABLE &&
		!PRESET_ROM_ENABLE)
		else $error("preset decode wrong");
	a_preset_access: assert property ((PRESET_CONFIG_SELECT == 2'h1) |-> HOST_ACCESS_OK)
		else $error("preset mode not accepting host");
	a_link_steady: assert property ((CE && LINK_VALID && !RX_BUSY && !TX_BUSY)
		|=> !LINK_ACTIVITY_INDICATOR_N)
		else $error("link indicator not on");
	a_duplex_full: assert property ((CE && FULL_DUPLEX) |=> !DUPLEX_INDICATOR_N)
		else $error("duplex indicator not on");
endmodule

bind ccw_chip_control ccw_cc_props i_props (.CLOCK, .RESETN, .CE, .IO_ADDR, .IO_RD, .IO_WR,
	.IO_RDATA, .IO_ACK, .FULL_DUPLEX, .LINK_VALID, .RX_BUSY, .TX_BUSY, .ROM_ACC_RD,
	.ROM_ACC_RDATA, .ROM_DEV_RD, .BOOT_ROM_BLOCK, .PRESET_CONFIG_SELECT, .HOST_ACCESS_OK,
	.PRESET_IO_BASE, .PRESET_IO_ENABLE, .PRESET_MEM_ENABLE, .PRESET_MASTER_ENABLE,
	.PRESET_ROM_ENABLE, .LINK_ACTIVITY_INDICATOR_N, .DUPLEX_INDICATOR_N);

`default_nettype wire

// ### testbench/ccw_testbench.sv
`timescale 1ns/1ps
`default_nettype none

// Counted compare; four-state so an unknown never matches
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
	$display("MISMATCH %0t got %h exp %h", $time, g, e); end end

module testbench;
	localparam logic [6:0] A = ccw_pkg::CCW_CHIP_CONTROL_OFFSET;
	logic clock = 1'b0;
	logic rst_n, ce, rd, wr, eev, cfgd, lv, l100, fdx, rxb, txb, col, rrd, rwr;
	logic ack, dev_rd, dev_wr, csrc, rsz, txo, rxo, rblk, alt, sim, hok, pio, pmem, pmst, prom;
	logic pwr_n, link_n, dpx_n, spd_n;
	logic [1:0] psel;
	logic [3:0] be;
	logic [5:0] pins;
	logic [6:0] addr;
	logic [7:0] eeb;
	logic [15:0] raddr, dev_addr, pbase;
	logic [31:0] wdata, rdata, rwdata, dev_rdata, acc_rdata, dev_wdata;
	int n_fail = 0;
	int cmp_count = 0;

	// Short blink so a whole period fits the run, same 1:8 ratio
	ccw_chip_control #(.BLINK_PERIOD_CYC(21'd640), .BLINK_ON_CYC(21'd80)) i_dut (
		.CLOCK(clock), .RESETN(rst_n), .CE(ce), .IO_ADDR(addr), .IO_RD(rd), .IO_WR(wr),
		.IO_BE(be), .IO_WDATA(wdata), .IO_RDATA(rdata), .IO_ACK(ack), .EE_BYTE_VALID(eev),
		.EE_BYTE(eeb), .HOST_CONFIG_DONE(cfgd), .EXPANSION_DATA_PINS(pins),
		.LINK_VALID(lv), .LINK_SPEED_100(l100), .FULL_DUPLEX(fdx), .RX_BUSY(rxb),
		.TX_BUSY(txb), .COLLISION(col), .ROM_ACC_RD(rrd), .ROM_ACC_WR(rwr),
		.ROM_ACC_ADDR(raddr), .ROM_ACC_WDATA(rwdata), .ROM_DEV_RDATA(dev_rdata),
		.ROM_ACC_RDATA(acc_rdata), .ROM_DEV_RD(dev_rd), .ROM_DEV_WR(dev_wr),
		.ROM_DEV_ADDR(dev_addr), .ROM_DEV_WDATA(dev_wdata),
		.LOGIC_CLOCK_SOURCE_SELECT(csrc), .BOOT_ROM_SIZE_SELECT(rsz),
		.TX_OVERSIZE_ENABLE(txo), .RX_OVERSIZE_ENABLE(rxo), .BOOT_ROM_BLOCK(rblk),
		.PRESET_CONFIG_SELECT(psel), .ALT_IDENTITY_SELECT(alt), .SIM_ACCELERATE(sim),
		.HOST_ACCESS_OK(hok), .PRESET_IO_BASE(pbase), .PRESET_IO_ENABLE(pio),
		.PRESET_MEM_ENABLE(pmem), .PRESET_MASTER_ENABLE(pmst), .PRESET_ROM_ENABLE(prom),
		.POWER_INDICATOR_N(pwr_n), .LINK_ACTIVITY_INDICATOR_N(link_n),
		.DUPLEX_INDICATOR_N(dpx_n), .SPEED_INDICATOR_N(spd_n)
	);

	// 25 MHz clock
	always #20 clock = ~clock;

	////////////////////////////////////////////////////////////////////////////////
	task report_and_stop;
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Inputs always move 1 ns after the edge
	task tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	// Straps must be steady before release, they are sampled after it
	task do_reset(input logic [5:0] p);
		pins = p;
		rst_n = 1'b0;
		tick(3);
		rst_n = 1'b1;
		tick(5);
	endtask

	// One register access; ack and read data stand in the next cycle only
	// Spare edge first so back-to-back calls never re-raise a strobe at once
	task io(input logic w, input logic [6:0] a, input logic [3:0] b, input logic [31:0] d,
		input logic ak, input logic [31:0] exp);
		tick(1);
		addr = a;
		be = b;
		wdata = d;
		wr = w;
		rd = !w;
		tick(1);
		wr = 1'b0;
		rd = 1'b0;
		`CHK(ack, ak)
		`CHK(rdata, w ? 32'h0 : exp)
	endtask

	task ee(input logic [7:0] b);
		eeb = b;
		eev = 1'b1;
		tick(1);
		eev = 1'b0;
		tick(1);
	endtask

	task rom(input logic w, input logic [15:0] a);
		raddr = a;
		rwr = w;
		rrd = !w;
		tick(1);
		rrd = 1'b0;
		rwr = 1'b0;
	endtask

	// Low cycles of one indicator over one full blink period
	task lows(input logic [1:0] d, input int exp);
		int n;
		n = 0;
		tick(3);
		repeat (640) begin
			if (((d == 2'd2) ? pwr_n : (d[0] ? dpx_n : link_n)) === 1'b0) n++;
			tick(1);
		end
		`CHK(n, exp)
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task t_straps;
		do_reset(6'b001100);
		io(1'b0, A, 4'hF, 32'h0, 1'b1, 32'h0000_0500);
		`CHK({psel, alt}, 3'b011)
		`CHK({hok, pbase, pio, pmst, pmem, prom}, {1'b1, 16'h0200, 4'b1100})
		rom(1'b0, 16'h0010);
		`CHK(dev_rd, 1'b0)
		do_reset(6'b100000);
		io(1'b0, A, 4'hF, 32'h0, 1'b1, 32'h0000_2000);
		`CHK(sim, 1'b1)
		do_reset(6'h00);
		io(1'b0, A, 4'hF, 32'h0, 1'b1, 32'h0);
		$display("test straps done");
	endtask

	task t_eeprom;
		`CHK(hok, 1'b0)
		ee(8'hE3);
		cfgd = 1'b1;
		io(1'b0, A, 4'hF, 32'h0, 1'b1, 32'h0000_00E3);
		`CHK({csrc, rsz}, 2'b11)
		tick(2);
		`CHK(hok, 1'b1)
		$display("test eeprom done");
	endtask

	task t_fields;
		ee(8'h00);
		io(1'b1, A, 4'hF, 32'hFFFF_FFFF, 1'b1, 32'h0);
		io(1'b0, A, 4'hF, 32'h0, 1'b1, 32'h0000_671C);
		`CHK({txo, rxo, rblk, psel, pbase}, {5'b11111, 16'h0})
		io(1'b1, A, 4'h2, 32'h0, 1'b1, 32'h0);
		io(1'b1, 7'h34, 4'hF, 32'h0, 1'b0, 32'h0);
		io(1'b0, A, 4'hF, 32'h0, 1'b1, 32'h0000_001C);
		$display("test fields done");
	endtask

	task t_rom;
		rom(1'b1, 16'h0040);
		`CHK(dev_wr, 1'b0)
		tick(1);
		`CHK(acc_rdata, 32'h0)
		io(1'b1, A, 4'h1, 32'h0, 1'b1, 32'h0);
		tick(1);
		rom(1'b0, 16'hFFFF);
		`CHK({dev_rd, dev_addr}, {1'b1, 16'h7FFF})
		tick(1);
		`CHK(acc_rdata, 32'hA5A5_5A5A)
		rwdata = 32'h1234_5678;
		rom(1'b1, 16'h0004);
		`CHK({dev_wr, dev_wdata}, {1'b1, 32'h1234_5678})
		ee(8'h02);
		rom(1'b0, 16'hFFFF);
		`CHK(dev_addr, 16'hFFFF)
		// Frozen block takes no write and gives no ack
		ce = 1'b0;
		io(1'b1, A, 4'h1, 32'h0000_0010, 1'b0, 32'h0);
		ce = 1'b1;
		io(1'b0, A, 4'hF, 32'h0, 1'b1, 32'h0000_0002);
		$display("test rom done");
	endtask

	task t_leds;
		lv = 1'b1;
		fdx = 1'b1;
		tick(2);
		`CHK({link_n, dpx_n}, 2'b00)
		fdx = 1'b0;
		io(1'b1, A, 4'h2, 32'h0000_4000, 1'b1, 32'h0);
		tick(3);
		`CHK(dpx_n, 1'b1)
		lv = 1'b0;
		txb = 1'b1;
		lows(2'd0, 80);
		io(1'b1, A, 4'h2, 32'h0, 1'b1, 32'h0);
		lows(2'd0, 0);
		lows(2'd2, 80);
		txb = 1'b0;
		rxb = 1'b1;
		lows(2'd0, 80);
		col = 1'b1;
		lows(2'd1, 80);
		lv = 1'b1;
		l100 = 1'b1;
		tick(2);
		`CHK({pwr_n, spd_n}, 2'b00)
		$display("test leds done");
	endtask

	// Hang guard
	initial begin
		repeat (100000) @(posedge clock);
		n_fail++;
		$display("MISMATCH %0t watchdog expired", $time);
		report_and_stop;
	end

	// Main sequence
	initial begin
		{rd, wr, eev, cfgd, lv, l100, fdx, rxb, txb, col, rrd, rwr} = '0;
		{addr, be, wdata, eeb, raddr, rwdata} = '0;
		dev_rdata = 32'hA5A5_5A5A;
		ce = 1'b1;
		t_straps;
		t_eeprom;
		t_fields;
		t_rom;
		t_leds;
		report_and_stop;
	end
endmodule

`default_nettype wire
